// File: design/sae_defines.vh
// sae_defines.vh: constants of the stack address environment block
// assumes: included by bare name from every design file of the block
`ifndef SAE_DEFINES_VH
`define SAE_DEFINES_VH
// widths
`define SAE_AW 20
`define SAE_DW 51
`define SAE_IW 16
// register byte offsets (32-bit words on the AHB-Lite port)
`define SAE_R_CMD 8'h00
`define SAE_R_COUPLE 8'h04
`define SAE_R_STATUS 8'h08
`define SAE_R_SPTR 8'h0C
`define SAE_R_FPTR 8'h10
`define SAE_R_DSEL 8'h14
`define SAE_R_DDATA 8'h18
`define SAE_R_WSEL 8'h1C
`define SAE_R_WLO 8'h20
`define SAE_R_WHI 8'h24
`define SAE_R_STKNO 8'h28
`define SAE_R_LIT 8'h2C
`define SAE_R_PARAM 8'h30
`define SAE_R_RESULT 8'h34
`define SAE_R_HANDLER 8'h38
// commands, written to the low bits of the command register
`define SAE_OP_REF 3'h1
`define SAE_OP_ENTER 3'h2
`define SAE_OP_EXIT 3'h3
`define SAE_OP_INTR 3'h4
`define SAE_OP_LOCATE 3'h5
// status bits
`define SAE_ST_BUSY 0
`define SAE_ST_DONE 1
`define SAE_ST_PRES 2
`define SAE_ST_TOPV 3
`define SAE_ST_SECV 4
`define SAE_ST_STRB 5
`define SAE_ST_RANGE 6
// working register indices
`define SAE_W_TOP 3'h0
`define SAE_W_SEC 3'h1
`define SAE_W_GEN 3'h2
`define SAE_W_XTOP 3'h3
`define SAE_W_XSEC 3'h4
`define SAE_W_INSTR 3'h5
`define SAE_W_LAST 3'h5
// procedure mark word fields
`define SAE_MK_HIST 19:0
`define SAE_MK_LINK 35:20
`define SAE_MK_LVL 40:36
`define SAE_MK_STK 50:41
// stack descriptor fields
`define SAE_SD_BASE 19:0
`define SAE_SD_LEN 35:20
`define SAE_SD_PRES 48
// reserved trunk slot of the stack vector descriptor, relative to level 0
`define SAE_SVD_SLOT 16'h0002
`endif

// File: design/sae_addr_adder.v
// sae_addr_adder.v: unsigned base plus index address adder
// assumes: purely combinational, result wraps inside the memory space
`timescale 1ns/10ps
`include "sae_defines.vh"
module sae_addr_adder (
  input wire [`SAE_AW-1:0] base,
  input wire [`SAE_IW-1:0] index,
  output wire [`SAE_AW-1:0] sum
);
  // unsigned add, carry out dropped on purpose, no overflow flag
  assign sum = base + {{(`SAE_AW-`SAE_IW){1'b0}}, index}; // RQ20
endmodule

// File: design/sae_stack_env.v
// sae_stack_env.v: stack addressing environment with AHB-Lite registers
// assumes: one 20 MHz clock hclk, async active-low reset, a memory port
// that holds mem_req until a one-cycle mem_ack with read data
//
// Operation
// RQ1: level part selects display base register
// RQ2: address is display base plus index
// RQ3: entry and exit rewrite display registers
// RQ4: entry writes stack number and link offset
// RQ5: interrupt pushes mark, reference, literal, parameter
// RQ6: handler entry and return update displays
// RQ7: stack number indexes the stack vector
// RQ8: descriptor gives branch length and presence
// RQ9: vector descriptor read from reserved trunk slot
// RQ10: absent branch raises presence-bit interrupt
// RQ11: top register valid only with its flag
// RQ12: second register valid only with its flag
// RQ13: general register holds memory returned word
// RQ14: two extension registers for double precision
// RQ15: instruction register holds current program word
// RQ16: new run needs only a level-2 branch
// RQ17: family A strobe set only by command
// RQ18: thirty-two display base registers
// RQ19: exit cuts stack, frame to previous mark
// RQ20: address add is unsigned without overflow
// RQ21: one memory request, wait for completion
`timescale 1ns/10ps
`include "sae_defines.vh"
module sae_stack_env (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_ff,
  output reg hreadyout_ff,
  output reg hresp_ff,
  output reg mem_req_ff,
  output reg mem_we_ff,
  output reg [`SAE_AW-1:0] mem_addr_ff,
  output reg [`SAE_DW-1:0] mem_wdata_ff,
  input wire mem_ack,
  input wire [`SAE_DW-1:0] mem_rdata,
  input wire z10_strobe_set,
  output reg family_a_strobe_ff,
  output reg presence_irq_ff
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_REF = 4'h1;
  localparam [3:0] ST_MARK = 4'h2;
  localparam [3:0] ST_IRW = 4'h3;
  localparam [3:0] ST_LIT = 4'h4;
  localparam [3:0] ST_PRM = 4'h5;
  localparam [3:0] ST_EXIT = 4'h6;
  localparam [3:0] ST_WALK = 4'h7;
  localparam [3:0] ST_SVD = 4'h8;
  localparam [3:0] ST_SD = 4'h9;

  reg [3:0] state_ff;
  reg [2:0] op_ff;
  reg wr_ff;
  reg [7:0] wad_ff;
  reg [4:0] lvl_ff;
  reg [`SAE_IW-1:0] idx_ff;
  reg [4:0] cur_lvl_ff;
  reg [`SAE_AW-1:0] sptr_ff;
  reg [`SAE_AW-1:0] fptr_ff;
  reg [`SAE_AW-1:0] link_offset_field_ff [0:31]; // RQ18
  reg [`SAE_DW-1:0] wreg_ff [0:5];
  reg top_valid_ff;
  reg sec_valid_ff;
  reg done_ff;
  reg range_ff;
  reg [4:0] dsel_ff;
  reg [2:0] wsel_ff;
  reg [9:0] stkno_ff;
  reg [31:0] lit_ff;
  reg [31:0] param_ff;
  reg [31:0] handler_ff;
  reg [31:0] result_ff;
  reg [`SAE_AW-1:0] walk_ff;
  reg walk_first_ff;
  reg [31:0] rd_mux;
  reg [`SAE_AW-1:0] add_base;
  reg [`SAE_IW-1:0] add_idx;
  wire [`SAE_AW-1:0] add_sum;
  wire ap;
  wire [`SAE_AW-1:0] new_mark;
  wire [`SAE_AW-1:0] parent;
  wire [`SAE_DW-1:0] mark_word;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // address adder shared by references and descriptor lookups
  always @* begin
    add_base = link_offset_field_ff[haddr[4:0]];
    add_idx = hwdata[`SAE_IW-1:0];
    if (state_ff == ST_SVD) begin
      add_base = mem_rdata[`SAE_SD_BASE];
      add_idx = {6'h00, stkno_ff}; // RQ7
    end else if (hwdata[2:0] == `SAE_OP_LOCATE) begin
      add_base = link_offset_field_ff[0];
      add_idx = `SAE_SVD_SLOT; // RQ9
    end else begin
      add_base = link_offset_field_ff[lvl_ff]; // RQ1
      add_idx = idx_ff;
    end
  end

  sae_addr_adder u_adder (
    .base(add_base),
    .index(add_idx),
    .sum(add_sum)
  );

  // new mark cell sits just above the stack top
  assign new_mark = sptr_ff + {{(`SAE_AW-1){1'b0}}, 1'b1};
  // enclosing level's mark, the one lying below the declaration
  assign parent = (lvl_ff == 5'h00) ? new_mark : link_offset_field_ff[lvl_ff - 5'h01];
  assign mark_word = {stkno_ff, lvl_ff,
                      new_mark[`SAE_IW-1:0] - parent[`SAE_IW-1:0], fptr_ff}; // RQ4

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase qualifier and read mux
  assign ap = hsel & htrans[1] & hready;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `SAE_R_COUPLE: rd_mux = {11'h000, lvl_ff, idx_ff};
      `SAE_R_STATUS: rd_mux = {25'h000_0000, range_ff, family_a_strobe_ff,
                               sec_valid_ff, top_valid_ff, presence_irq_ff,
                               done_ff, (state_ff != ST_IDLE)};
      `SAE_R_SPTR: rd_mux = {12'h000, sptr_ff};
      `SAE_R_FPTR: rd_mux = {12'h000, fptr_ff};
      `SAE_R_DSEL: rd_mux = {27'h000_0000, dsel_ff};
      `SAE_R_DDATA: rd_mux = {12'h000, link_offset_field_ff[dsel_ff]};
      `SAE_R_WSEL: rd_mux = {29'h0000_0000, wsel_ff};
      `SAE_R_WLO: rd_mux = wreg_ff[wsel_ff][31:0];
      `SAE_R_WHI: rd_mux = {13'h0000, wreg_ff[wsel_ff][`SAE_DW-1:32]};
      `SAE_R_STKNO: rd_mux = {22'h00_0000, stkno_ff};
      `SAE_R_LIT: rd_mux = lit_ff;
      `SAE_R_PARAM: rd_mux = param_ff;
      `SAE_R_RESULT: rd_mux = result_ff;
      `SAE_R_HANDLER: rd_mux = handler_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // zero wait states, always OKAY; read data captured in address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_ff <= 1'b0;
      wad_ff <= 8'h00;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_ff <= ap & hwrite;
      if (ap) begin
        wad_ff <= haddr[7:0];
        hrdata_ff <= hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer, memory port and software writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      op_ff <= 3'h0;
      lvl_ff <= 5'h00;
      idx_ff <= 16'h0000;
      cur_lvl_ff <= 5'h00;
      sptr_ff <= 20'h0_0000;
      fptr_ff <= 20'h0_0000;
      for (i = 0; i < 32; i = i + 1) begin
        link_offset_field_ff[i] <= 20'h0_0000;
      end
      for (i = 0; i <= `SAE_W_LAST; i = i + 1) begin
        wreg_ff[i] <= 51'h0;
      end
      top_valid_ff <= 1'b0;
      sec_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      range_ff <= 1'b0;
      presence_irq_ff <= 1'b0;
      family_a_strobe_ff <= 1'b0;
      dsel_ff <= 5'h00;
      wsel_ff <= 3'h0;
      stkno_ff <= 10'h000;
      lit_ff <= 32'h0000_0000;
      param_ff <= 32'h0000_0000;
      handler_ff <= 32'h0000_0000;
      result_ff <= 32'h0000_0000;
      walk_ff <= 20'h0_0000;
      walk_first_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 20'h0_0000;
      mem_wdata_ff <= 51'h0;
    end else begin
      // software writes; clears come first so hardware sets win below
      if (wr_ff) begin
        case (wad_ff)
          `SAE_R_COUPLE: begin
            lvl_ff <= hwdata[20:16];
            idx_ff <= hwdata[15:0];
          end
          `SAE_R_STATUS: begin
            if (hwdata[`SAE_ST_DONE]) done_ff <= 1'b0;
            if (hwdata[`SAE_ST_PRES]) presence_irq_ff <= 1'b0;
            if (hwdata[`SAE_ST_RANGE]) range_ff <= 1'b0;
            if (hwdata[`SAE_ST_STRB]) family_a_strobe_ff <= 1'b0;
            top_valid_ff <= hwdata[`SAE_ST_TOPV]; // RQ11
            sec_valid_ff <= hwdata[`SAE_ST_SECV]; // RQ12
          end
          `SAE_R_SPTR: if (state_ff == ST_IDLE) sptr_ff <= hwdata[19:0];
          `SAE_R_FPTR: if (state_ff == ST_IDLE) fptr_ff <= hwdata[19:0];
          `SAE_R_DSEL: dsel_ff <= hwdata[4:0];
          `SAE_R_DDATA: if (state_ff == ST_IDLE) link_offset_field_ff[dsel_ff] <= hwdata[19:0];
          `SAE_R_WSEL: wsel_ff <= (hwdata[2:0] > `SAE_W_LAST) ? `SAE_W_LAST : hwdata[2:0];
          `SAE_R_WLO: wreg_ff[wsel_ff][31:0] <= hwdata; // RQ14 RQ15
          `SAE_R_WHI: wreg_ff[wsel_ff][`SAE_DW-1:32] <= hwdata[18:0];
          `SAE_R_STKNO: stkno_ff <= hwdata[9:0];
          `SAE_R_LIT: lit_ff <= hwdata;
          `SAE_R_PARAM: param_ff <= hwdata;
          `SAE_R_HANDLER: handler_ff <= hwdata;
          default: ;
        endcase
      end
      // strobe may only be set by the program controller's command
      if (z10_strobe_set) family_a_strobe_ff <= 1'b1; // RQ17
      // a memory request stands until the acknowledge, then drops
      if (mem_ack) mem_req_ff <= 1'b0; // RQ21
      case (state_ff)
        ST_IDLE: begin
          if (wr_ff && wad_ff == `SAE_R_CMD) begin
            op_ff <= hwdata[2:0];
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= add_sum;
            case (hwdata[2:0])
              `SAE_OP_REF: state_ff <= ST_REF; // RQ2
              `SAE_OP_ENTER, `SAE_OP_INTR: begin
                mem_we_ff <= 1'b1;
                mem_addr_ff <= new_mark;
                mem_wdata_ff <= mark_word;
                state_ff <= ST_MARK;
              end
              `SAE_OP_EXIT: begin
                mem_addr_ff <= fptr_ff;
                state_ff <= ST_EXIT;
              end
              `SAE_OP_LOCATE: state_ff <= ST_SVD; // RQ9
              default: mem_req_ff <= 1'b0;
            endcase
          end
        end
        ST_REF: if (mem_ack) begin
          // fetched word lands in the general register
          wreg_ff[`SAE_W_GEN] <= mem_rdata; // RQ13
          result_ff <= {12'h000, mem_addr_ff};
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        ST_MARK: if (mem_ack) begin
          // new frame: display of the entered level points at its mark
          link_offset_field_ff[lvl_ff] <= new_mark; // RQ3 RQ6
          cur_lvl_ff <= lvl_ff;
          fptr_ff <= new_mark;
          sptr_ff <= new_mark;
          result_ff <= {12'h000, new_mark};
          if (op_ff == `SAE_OP_INTR) begin
            mem_req_ff <= 1'b1;
            mem_addr_ff <= new_mark + 20'h0_0001;
            mem_wdata_ff <= {19'h0_0000, handler_ff}; // RQ5
            state_ff <= ST_IRW;
          end else begin
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        ST_IRW: if (mem_ack) begin
          sptr_ff <= mem_addr_ff;
          mem_req_ff <= 1'b1;
          mem_addr_ff <= mem_addr_ff + 20'h0_0001;
          mem_wdata_ff <= {19'h0_0000, lit_ff}; // RQ5
          state_ff <= ST_LIT;
        end
        ST_LIT: if (mem_ack) begin
          sptr_ff <= mem_addr_ff;
          mem_req_ff <= 1'b1;
          mem_addr_ff <= mem_addr_ff + 20'h0_0001;
          mem_wdata_ff <= {19'h0_0000, param_ff}; // RQ5
          state_ff <= ST_PRM;
        end
        ST_PRM: if (mem_ack) begin
          sptr_ff <= mem_addr_ff;
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        ST_EXIT: if (mem_ack) begin
          // cut back below the mark, frame moves to the previous mark
          sptr_ff <= fptr_ff - 20'h0_0001; // RQ19
          fptr_ff <= mem_rdata[`SAE_MK_HIST]; // RQ19
          walk_ff <= mem_rdata[`SAE_MK_HIST];
          walk_first_ff <= 1'b1;
          mem_req_ff <= 1'b1;
          mem_addr_ff <= mem_rdata[`SAE_MK_HIST];
          state_ff <= ST_WALK;
        end
        ST_WALK: if (mem_ack) begin
          // follow the static links downward; stop once a display agrees
          walk_first_ff <= 1'b0;
          if (walk_first_ff) cur_lvl_ff <= mem_rdata[`SAE_MK_LVL];
          link_offset_field_ff[mem_rdata[`SAE_MK_LVL]] <= walk_ff; // RQ3 RQ6
          if (mem_rdata[`SAE_MK_LVL] == 5'h00 ||
              (!walk_first_ff && link_offset_field_ff[mem_rdata[`SAE_MK_LVL]] == walk_ff)) begin
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            walk_ff <= walk_ff - {4'h0, mem_rdata[`SAE_MK_LINK]};
            mem_req_ff <= 1'b1;
            mem_addr_ff <= walk_ff - {4'h0, mem_rdata[`SAE_MK_LINK]};
          end
        end
        ST_SVD: if (mem_ack) begin
          // stack number beyond the vector length is refused
          if ({6'h00, stkno_ff} >= mem_rdata[`SAE_SD_LEN]) begin
            range_ff <= 1'b1;
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            mem_req_ff <= 1'b1;
            mem_addr_ff <= add_sum; // RQ7
            state_ff <= ST_SD;
          end
        end
        ST_SD: if (mem_ack) begin
          // a level-2 branch is just another descriptor; code is shared
          result_ff <= {mem_rdata[31:20], mem_rdata[`SAE_SD_BASE]}; // RQ8 RQ16
          if (!mem_rdata[`SAE_SD_PRES]) presence_irq_ff <= 1'b1; // RQ10
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: tb/sae_mem_model.sv
// sae_mem_model.sv: behavioural main memory on the far side of the block
// assumes: one request held until a one-cycle ack, word address in addr
`timescale 1ns/10ps
module sae_mem_model (
  input wire hclk,
  input wire req,
  input wire we,
  input wire [19:0] addr,
  input wire [50:0] wdata,
  output logic ack,
  output logic [50:0] rdata
);
  logic [50:0] mem [0:1023];
  int lat = 0;
  int cnt = 0;
  ////////////////////////////////////////////////////////////////////////
  // one ack per request after lat wait cycles; the ack cycle itself is
  // skipped so a request the block keeps up is not answered twice
  always @(posedge hclk) begin
    ack <= 1'b0;
    rdata <= ~rdata; // released lines invert each cycle instead of holding the last word read
    if (req && !ack) begin
      if (cnt >= lat) begin
        cnt <= 0;
        ack <= 1'b1;
        rdata <= mem[addr[9:0]];
        if (we)
          mem[addr[9:0]] <= wdata;
      end else
        cnt <= cnt + 1;
    end
  end
  initial begin
    ack = 1'b0;
    rdata = '0;
  end
endmodule

// File: tb/sae_stack_env_sva.sv
// sae_stack_env_sva.sv: port-level checker for the stack environment
// assumes: bound to sae_stack_env; one clock, async active-low reset
`timescale 1ns/10ps
module sae_stack_env_sva (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata_ff,
  input wire hreadyout_ff,
  input wire hresp_ff,
  input wire mem_req_ff,
  input wire mem_we_ff,
  input wire [19:0] mem_addr_ff,
  input wire [50:0] mem_wdata_ff,
  input wire mem_ack,
  input wire z10_strobe_set,
  input wire family_a_strobe_ff,
  input wire presence_irq_ff
);
  ////////////////////////////////////////////////////////////////////////
  // one domain, so clock and reset are given once
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // address phase accepted by the slave
  wire take = hsel && htrans[1] && hready;
  bus_okay_a: assert property (hreadyout_ff && !hresp_ff)
    else $error("bus not ready or error response");
  req_hold_a: assert property (mem_req_ff && !mem_ack |=> mem_req_ff &&
    $stable(mem_addr_ff) && $stable(mem_we_ff) && $stable(mem_wdata_ff))
    else $error("memory request changed before ack");
  req_drop_a: assert property ($fell(mem_req_ff) |-> $past(mem_ack))
    else $error("memory request dropped without ack");
  ref_read_a: assert property (take && hwrite && haddr[7:0] == 8'h00 &&
    !mem_req_ff ##1 hwdata[2:0] == 3'h1 |=> ##[0:2] (mem_req_ff && !mem_we_ff))
    else $error("reference command issued no memory read");
  strobe_set_a: assert property (z10_strobe_set |=> family_a_strobe_ff)
    else $error("strobe not set by command");
  strobe_cause_a: assert property ($rose(family_a_strobe_ff) |->
    $past(z10_strobe_set))
    else $error("strobe set without command");
  // a write clears at its data-phase edge, one cycle after the address phase
  irq_sticky_a: assert property (presence_irq_ff && !$past(take && hwrite)
    |=> presence_irq_ff)
    else $error("presence interrupt lost without a write");
  rdata_hold_a: assert property (!take |=> $stable(hrdata_ff))
    else $error("read data changed without a transfer");
endmodule

// File: tb/tb_top.sv
// tb_top.sv: register-level tests of the stack environment block
// assumes: design, memory model and checker compiled before this file
`timescale 1ns/10ps
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic z10_strobe_set = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire [31:0] hrdata_ff;
  wire hreadyout_ff, hresp_ff, mem_req_ff, mem_we_ff, mem_ack;
  wire family_a_strobe_ff, presence_irq_ff;
  wire [19:0] mem_addr_ff;
  wire [50:0] mem_wdata_ff, mem_rdata;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  sae_stack_env dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .z10_strobe_set(z10_strobe_set), .family_a_strobe_ff(family_a_strobe_ff),
    .presence_irq_ff(presence_irq_ff));
  sae_mem_model far (.hclk(hclk), .req(mem_req_ff), .we(mem_we_ff), .addr(mem_addr_ff),
    .wdata(mem_wdata_ff), .ack(mem_ack), .rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////
  // 20 MHz clock and a cycle ceiling against hangs
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // single non-pipelined transfer; waits on hready, no fixed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout_ff !== 1'b1);
    rd = hrdata_ff;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check({32'h0, rd}, {32'h0, e});
  endtask
  // a command is finished once done shows; done is then cleared
  task automatic op(input logic [2:0] c);
    bus(1'b1, 8'h00, {29'h0, c});
    rd = 32'h0;
    while (rd[1] !== 1'b1)
      bus(1'b0, 8'h08, 32'h0);
    bus(1'b1, 8'h08, 32'h2);
  endtask
  task automatic link_offset_field(input logic [4:0] i, input logic [19:0] v);
    bus(1'b1, 8'h14, {27'h0, i});
    bus(1'b1, 8'h18, {12'h0, v});
  endtask
  task automatic final_report();
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence: registers, strobe, reference, locate, entry, exit, interrupt
  initial begin
    for (int i = 0; i < 1024; i++) begin
      far.mem[i] = '0;
    end
    far.mem[10'h105] = 51'h7_1234_5678_9ABC;
    far.mem[10'h001] = 51'h2_0000_0000_0005;
    far.mem[10'h202] = {3'h1, 12'h0, 16'h0008, 20'h00300};
    far.mem[10'h302] = {3'h1, 12'h0, 16'h0010, 20'h00400};
    far.mem[10'h303] = {3'h0, 12'h0, 16'h0010, 20'h00500};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(8'h08, 32'h0);
    bus(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h1C, i);
      bus(1'b1, 8'h20, 32'hA5A5_0000 + i);
      bus(1'b1, 8'h24, 32'h0005_5000 + i);
    end
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h1C, i);
      rchk(8'h20, 32'hA5A5_0000 + i);
      rchk(8'h24, 32'h0005_5000 + i);
    end
    bus(1'b1, 8'h1C, 32'h7);
    rchk(8'h20, 32'hA5A5_0005);
    bus(1'b1, 8'h08, 32'h18);
    rchk(8'h08, 32'h18);
    bus(1'b1, 8'h08, 32'h8);
    rchk(8'h08, 32'h8);
    z10_strobe_set <= 1'b1;
    @(posedge hclk);
    z10_strobe_set <= 1'b0;
    @(posedge hclk);
    rchk(8'h08, 32'h28);
    bus(1'b1, 8'h08, 32'h20);
    // the clear lands at the data-phase edge; look once it has settled
    @(posedge hclk);
    check(family_a_strobe_ff, 1'b0);
    link_offset_field(5'd3, 20'h00100);
    link_offset_field(5'd31, 20'hFFFFF);
    rchk(8'h18, 32'h000F_FFFF);
    bus(1'b1, 8'h04, {11'h0, 5'd3, 16'h0005});
    op(3'h1);
    bus(1'b1, 8'h1C, 32'h2);
    rchk(8'h20, 32'h5678_9ABC);
    rchk(8'h24, 32'h0007_1234);
    far.lat = 2;
    bus(1'b1, 8'h04, {11'h0, 5'd31, 16'h0002});
    op(3'h1);
    rchk(8'h20, 32'h0000_0005);
    far.lat = 0;
    link_offset_field(5'd0, 20'h00200);
    bus(1'b1, 8'h28, 32'h2);
    op(3'h5);
    rchk(8'h34, 32'h0100_0400);
    bus(1'b1, 8'h28, 32'h3);
    op(3'h5);
    check(presence_irq_ff, 1'b1);
    rchk(8'h08, 32'h4);
    bus(1'b1, 8'h08, 32'h4);
    @(posedge hclk);
    check(presence_irq_ff, 1'b0);
    bus(1'b1, 8'h28, 32'h9);
    op(3'h5);
    rchk(8'h08, 32'h40);
    bus(1'b1, 8'h08, 32'h40);
    link_offset_field(5'd1, 20'h004F0);
    bus(1'b1, 8'h0C, 32'h500);
    bus(1'b1, 8'h10, 32'h480);
    bus(1'b1, 8'h04, {11'h0, 5'd2, 16'h0000});
    bus(1'b1, 8'h28, 32'h5);
    op(3'h2);
    check(far.mem[10'h101], {10'd5, 5'd2, 16'h0011, 20'h00480});
    rchk(8'h0C, 32'h501);
    rchk(8'h10, 32'h501);
    bus(1'b1, 8'h14, 32'h2);
    rchk(8'h18, 32'h501);
    op(3'h3);
    rchk(8'h0C, 32'h500);
    rchk(8'h10, 32'h480);
    bus(1'b1, 8'h38, 32'h0ABC);
    bus(1'b1, 8'h2C, 32'h33);
    bus(1'b1, 8'h30, 32'h44);
    op(3'h4);
    check(far.mem[10'h102][31:0], 32'h0ABC);
    check(far.mem[10'h103][31:0], 32'h33);
    check(far.mem[10'h104][31:0], 32'h44);
    rchk(8'h0C, 32'h504);
    rchk(8'h10, 32'h501);
    final_report();
  end
endmodule
bind sae_stack_env sae_stack_env_sva chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
  .mem_req_ff(mem_req_ff), .mem_we_ff(mem_we_ff), .mem_addr_ff(mem_addr_ff),
  .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack), .z10_strobe_set(z10_strobe_set),
  .family_a_strobe_ff(family_a_strobe_ff), .presence_irq_ff(presence_irq_ff));
